/* design/mpm_pkg.sv */
// Purpose: shared constants and types for the multiphase pulse phase manager
// Assumes: 10 MHz core clock, four stages, two rails
// Notes: stage index 0..3 stands for outputs 1A, 1B, 2A, 3A
package mpm_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned NUM_STAGES = 4;
    localparam int unsigned NUM_RAILS = 2;
    // sampling step per configured stage, in microseconds
    localparam int unsigned SAMPLE_STEP_US = 200;
    localparam int unsigned SAMPLE_STEP_CYC = SAMPLE_STEP_US * (CLK_HZ / 1_000_000);
    // alignment routing word
    localparam logic [15:0] ALIGN_ROUTE_RST = 16'hff00;
    localparam int unsigned ALIGN_OUT_LSB = 8;
    localparam logic [7:0] ALIGN_OUT_LIMIT = 8'h04;
    // fixed-point multipliers over 2^16: 3/13 and 1/3
    localparam logic [15:0] SPREAD_MUL = 16'h3b13;
    localparam logic [15:0] THIRD_MUL = 16'h5556;
    // smoothing weight 1/4 gives a time constant near 3.5 intervals
    localparam int unsigned FILT_SHIFT = 2;
    localparam int unsigned CAL_SHIFT = 8;
    localparam logic [1:0] BANK_RAMP = 2'h0;
    localparam logic [1:0] BANK_REG = 2'h1;
    localparam logic [1:0] BANK_LIGHT = 2'h2;
    typedef enum logic [0:0] {
        MPM_ADC_IDLE = 1'b0,
        MPM_ADC_CONV = 1'b1
    } mpm_adc_state_t;
endpackage : mpm_pkg

/* design/mpm_phase_mgr.sv */
// Purpose: stage-to-rail mapping, phase spreading, alignment, shedding, current monitor
// Assumes: configuration inputs are quasi-static and on core_clk
// Notes: only sync_in comes from outside the clock domain
`timescale 1ns/100ps
module mpm_phase_mgr
    import mpm_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [4:0] stage_assignment_cmd,
    input wire logic [1:0][15:0] rail_period,
    input wire logic [1:0][15:0] rail_duty,
    input wire logic [1:0] rail_ramping,
    input wire logic align_wr,
    input wire logic [15:0] align_wdata,
    output logic [15:0] align_rdata_q,
    input wire logic soft_reset,
    input wire logic sync_in,
    output logic sync_out_q,
    output logic [3:0] pulse_output_q,
    output logic adc_start_q,
    output logic [1:0] adc_chan_q,
    input wire logic adc_done,
    input wire logic [11:0] adc_data,
    input wire logic [3:0][15:0] current_gain_cal,
    input wire logic [3:0][11:0] current_offset_cal,
    input wire logic [1:0][17:0] oc_limit,
    input wire logic [1:0][17:0] uc_limit,
    input wire logic fault_off_en,
    input wire logic [1:0] fault_clr,
    output logic [1:0] fault_q,
    input wire logic light_en,
    input wire logic light_coef_en,
    input wire logic [1:0][17:0] light_low,
    input wire logic [1:0][17:0] light_high,
    input wire logic [1:0] shed_num,
    output logic [1:0] shed_q,
    output logic [1:0][1:0] bank_q,
    output logic [1:0][17:0] rail_current_q,
    output logic cfg_invalid_q
);

    // {enabled, rail, position within rail}
    function automatic logic [3:0] stage_map(input logic [1:0] s, input logic [2:0] n0, input logic [1:0] n1);
        logic [3:0] m;
        m = 4'h0;
        unique case (s)
            2'd0: m = {n0 >= 3'd1, 1'b0, 2'd0};
            2'd1: m = {n0 >= 3'd2, 1'b0, 2'd1};
            2'd2: m = (n1 != 2'd0) ? {1'b1, 1'b1, 2'd0} : {n0 >= 3'd3, 1'b0, 2'd2};
            2'd3: begin
                if (n1 == 2'd2)
                    m = {1'b1, 1'b1, 2'd1};
                else if (n1 == 2'd1)
                    m = {n0 == 3'd3, 1'b0, 2'd2};
                else
                    m = {n0 == 3'd4, 1'b0, 2'd3};
            end
        endcase
        return m;
    endfunction : stage_map

    function automatic logic [15:0] phase_off(input logic [15:0] per, input logic [1:0] pos, input logic [2:0] n);
        logic [17:0] prod;
        logic [33:0] third;
        prod = per * pos;
        third = prod * THIRD_MUL;
        unique case (n)
            3'd2: return prod[16:1];
            3'd3: return third[31:16];
            3'd4: return prod[17:2];
            default: return 16'h0000;
        endcase
    endfunction : phase_off

    logic [2:0] n0;
    logic [1:0] n1;
    logic cfg_ok;
    logic [3:0][3:0] smap;
    logic [1:0][15:0] per_w;
    logic [15:0] per_min;
    logic [31:0] spread_prod;
    logic [15:0] spread;

    // stage mapping and configuration check
    always_comb begin
        n0 = stage_assignment_cmd[2:0];
        n1 = stage_assignment_cmd[4:3];
        // empty rail one, three on rail two, or over four total are refused
        cfg_ok = (n0 >= 3'd1) && (n0 <= 3'd4) && (n1 <= 2'd2) && ((n0 + {1'b0, n1}) <= 3'd4);
        for (int s = 0; s < NUM_STAGES; s++) begin
            smap[s] = stage_map(2'(s), n0, n1);
        end
        for (int r = 0; r < NUM_RAILS; r++) begin
            per_w[r] = (rail_period[r] == 16'h0000) ? 16'h0001 : rail_period[r];
        end
        per_min = (per_w[0] < per_w[1]) ? per_w[0] : per_w[1];
        spread_prod = per_min * SPREAD_MUL;
        spread = spread_prod[31:16];
    end

    // timing group: period counters, alignment, pulse outputs
    logic [1:0][15:0] cnt_q, cnt_d;
    logic sync_s1_q, sync_s2_q, sync_s3_q;
    logic sync_rise;
    logic lost_q, lost_d;
    logic [15:0] align_d;
    logic [3:0] pulse_d;
    logic sync_out_d;
    logic [3:0] per_start;
    logic [3:0][16:0] off_w;
    logic [3:0][16:0] lc_w;
    logic [3:0][31:0] thr_w;
    logic [3:0] keep_w;
    logic [1:0] restart;

    always_comb begin
        sync_rise = sync_s2_q && !sync_s3_q;
        for (int r = 0; r < NUM_RAILS; r++) begin
            restart[r] = sync_rise && align_rdata_q[r];
            // any rising input wins over the local wrap, so faster masters lock
            if (restart[r])
                cnt_d[r] = 16'h0000;
            else if (cnt_q[r] >= per_w[r] - 16'h0001)
                cnt_d[r] = 16'h0000;
            else
                cnt_d[r] = cnt_q[r] + 16'h0001;
        end
        // spacing stays lost once a rail follows, until soft reset; set wins over soft reset
        lost_d = soft_reset ? 1'b0 : lost_q;
        if (align_rdata_q[1:0] != 2'b00)
            lost_d = 1'b1;
        align_d = align_wr ? align_wdata : align_rdata_q;
        for (int s = 0; s < NUM_STAGES; s++) begin
            off_w[s] = {1'b0, phase_off(per_w[smap[s][2]], smap[s][1:0], smap[s][2] ? {1'b0, n1} : n0)};
            if (smap[s][2] && !lost_q)
                off_w[s] = off_w[s] + {1'b0, spread};
            if (off_w[s] >= {1'b0, per_w[smap[s][2]]})
                off_w[s] = off_w[s] - {1'b0, per_w[smap[s][2]]};
            if ({1'b0, cnt_q[smap[s][2]]} >= off_w[s])
                lc_w[s] = {1'b0, cnt_q[smap[s][2]]} - off_w[s];
            else
                lc_w[s] = {1'b0, cnt_q[smap[s][2]]} + {1'b0, per_w[smap[s][2]]} - off_w[s];
            thr_w[s] = rail_duty[smap[s][2]] * per_w[smap[s][2]];
            // shedding drops the highest positions first, position 0 always stays
            keep_w[s] = smap[s][3] && cfg_ok && !(fault_off_en && fault_q[smap[s][2]])
                && !(shed_q[smap[s][2]] && smap[s][1:0] != 2'd0
                && {1'b0, smap[s][1:0]} >= ((smap[s][2] ? {1'b0, n1} : n0) - {1'b0, shed_num}));
            pulse_d[s] = keep_w[s] && (lc_w[s] < {1'b0, thr_w[s][31:16]});
            per_start[s] = keep_w[s] && (lc_w[s] == 17'h00000);
        end
        sync_out_d = (align_rdata_q[15:ALIGN_OUT_LSB] < ALIGN_OUT_LIMIT)
            && per_start[align_rdata_q[ALIGN_OUT_LSB+1:ALIGN_OUT_LSB]];
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            sync_s1_q <= 1'b0;
            sync_s2_q <= 1'b0;
            sync_s3_q <= 1'b0;
            lost_q <= 1'b0;
            align_rdata_q <= ALIGN_ROUTE_RST;
            pulse_output_q <= 4'h0;
            sync_out_q <= 1'b0;
            cfg_invalid_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            sync_s1_q <= sync_in;
            sync_s2_q <= sync_s1_q;
            sync_s3_q <= sync_s2_q;
            lost_q <= lost_d;
            align_rdata_q <= align_d;
            pulse_output_q <= pulse_d;
            sync_out_q <= sync_out_d;
            cfg_invalid_q <= !cfg_ok;
        end
    end

    // monitor group: converter sequencing, calibration, smoothing, shed, fault
    mpm_adc_state_t adc_st_q, adc_st_d;
    logic [12:0] slot_q, slot_d;
    logic [12:0] slot_end;
    logic [31:0] slot_prod;
    logic tick;
    logic adc_start_d;
    logic [1:0] adc_chan_d;
    logic [3:0][15:0] avg_q, avg_d;
    logic [11:0] raw_w;
    logic [27:0] cal_prod;
    logic [15:0] cal_w;
    logic signed [17:0] diff_w;
    logic [1:0][17:0] sum_w;
    logic [1:0] shed_d, fault_d;
    logic [1:0][1:0] bank_d;
    logic [1:0] nxt_ch;
    logic [1:0] rail_on;

    always_comb begin
        // interval grows with the number of configured stages
        slot_prod = SAMPLE_STEP_CYC * ({29'h0, n0} + {30'h0, n1});
        slot_end = slot_prod[12:0] - 13'h0001;
        tick = (slot_q >= slot_end);
        slot_d = tick ? 13'h0000 : slot_q + 13'h0001;
        nxt_ch = adc_chan_q;
        for (int k = 3; k >= 1; k--) begin
            if (smap[2'(adc_chan_q + 2'(k))][3])
                nxt_ch = 2'(adc_chan_q + 2'(k));
        end
        adc_st_d = adc_st_q;
        adc_start_d = 1'b0;
        adc_chan_d = adc_chan_q;
        avg_d = avg_q;
        raw_w = (adc_data > current_offset_cal[adc_chan_q]) ? adc_data - current_offset_cal[adc_chan_q] : 12'h000;
        cal_prod = raw_w * current_gain_cal[adc_chan_q];
        cal_w = (cal_prod[27:24] != 4'h0) ? 16'hffff : cal_prod[23:CAL_SHIFT];
        diff_w = $signed({2'b00, cal_w}) - $signed({2'b00, avg_q[adc_chan_q]});
        unique case (adc_st_q)
            MPM_ADC_IDLE: begin
                // a conversion still running when the slot ends just skips that slot
                if (tick && cfg_ok) begin
                    adc_start_d = 1'b1;
                    adc_chan_d = nxt_ch;
                    adc_st_d = MPM_ADC_CONV;
                end
            end
            MPM_ADC_CONV: begin
                if (adc_done) begin
                    avg_d[adc_chan_q] = 16'(18'($signed({2'b00, avg_q[adc_chan_q]}) + (diff_w >>> FILT_SHIFT)));
                    adc_st_d = MPM_ADC_IDLE;
                end
            end
        endcase
        sum_w = '0;
        for (int s = 0; s < NUM_STAGES; s++) begin
            if (smap[s][3])
                sum_w[smap[s][2]] = sum_w[smap[s][2]] + {2'b00, avg_q[s]};
        end
        rail_on = {n1 != 2'd0, 1'b1};
        for (int r = 0; r < NUM_RAILS; r++) begin
            // thresholds apart keep the shed state from chattering
            if (!light_en)
                shed_d[r] = 1'b0;
            else if (shed_q[r])
                shed_d[r] = !(rail_current_q[r] > light_high[r]);
            else
                shed_d[r] = rail_current_q[r] < light_low[r];
            // averaged value only; an arriving fault beats the clear
            fault_d[r] = fault_q[r] && !fault_clr[r];
            if (rail_on[r] && cfg_ok && (rail_current_q[r] > oc_limit[r] || rail_current_q[r] < uc_limit[r]))
                fault_d[r] = 1'b1;
            if (rail_ramping[r])
                bank_d[r] = BANK_RAMP;
            else if (shed_q[r] && light_coef_en)
                bank_d[r] = BANK_LIGHT;
            else
                bank_d[r] = BANK_REG;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            adc_st_q <= MPM_ADC_IDLE;
            slot_q <= 13'h0000;
            adc_start_q <= 1'b0;
            adc_chan_q <= 2'd0;
            avg_q <= '0;
            rail_current_q <= '0;
            shed_q <= 2'b00;
            fault_q <= 2'b00;
            bank_q <= '0;
        end else begin
            adc_st_q <= adc_st_d;
            slot_q <= slot_d;
            adc_start_q <= adc_start_d;
            adc_chan_q <= adc_chan_d;
            avg_q <= avg_d;
            rail_current_q <= sum_w;
            shed_q <= shed_d;
            fault_q <= fault_d;
            bank_q <= bank_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_cfg_refused;
        !cfg_ok |=> (pulse_output_q == 4'h0);
    endproperty
    a_cfg_refused: assert property (p_cfg_refused) else $error("invalid split drove an output");

    property p_follow_restart;
        (sync_rise && align_rdata_q[0]) |=> (cnt_q[0] == 16'h0000) ##1 (cnt_q[0] <= 16'h0001);
    endproperty
    a_follow_restart: assert property (p_follow_restart) else $error("rail did not restart on alignment");

    property p_spacing_lost;
        (align_rdata_q[1:0] != 2'b00) |=> lost_q [*2];
    endproperty
    a_spacing_lost: assert property (p_spacing_lost) else $error("spacing kept while following");

    property p_align_out_source;
        sync_out_q |-> $past(align_rdata_q[15:8] < ALIGN_OUT_LIMIT && keep_w[align_rdata_q[9:8]]);
    endproperty
    a_align_out_source: assert property (p_align_out_source) else $error("alignment out from disabled source");

    property p_shed_hyst;
        $fell(shed_q[0]) |-> $past(!light_en || rail_current_q[0] > light_high[0]);
    endproperty
    a_shed_hyst: assert property (p_shed_hyst) else $error("stages added below high limit");

    property p_fault_cause;
        $rose(fault_q[0]) |-> $past(rail_current_q[0] > oc_limit[0] || rail_current_q[0] < uc_limit[0]);
    endproperty
    a_fault_cause: assert property (p_fault_cause) else $error("fault without averaged excursion");

    property p_adc_single;
        adc_start_q |=> !adc_start_q ##0 (adc_st_q == MPM_ADC_CONV);
    endproperty
    a_adc_single: assert property (p_adc_single) else $error("converter start not a single pulse");

    property p_bank_ramp;
        rail_ramping[1] |=> (bank_q[1] == BANK_RAMP);
    endproperty
    a_bank_ramp: assert property (p_bank_ramp) else $error("ramp did not select bank 0");

endmodule : mpm_phase_mgr

/* dv/mpm_far_model.sv */
// Purpose: converter and peer alignment source facing the phase manager
// Assumes: one conversion outstanding, answer a fixed number of cycles after start
// Notes: data line inverts itself every cycle outside done, so a stale sample never holds steady
`timescale 1ns/100ps
module mpm_far_model
    import mpm_pkg::*;
#(
    parameter int unsigned CONV_CYC = 5,
    parameter int unsigned SYNC_CYC = 80
) (
    input wire logic core_clk,
    input wire logic adc_start_q,
    input wire logic [1:0] adc_chan_q,
    input wire logic [3:0][11:0] chan_level,
    input wire logic sync_en,
    output logic adc_done,
    output logic [11:0] adc_data,
    output logic sync_in
);
    int unsigned busy_cnt = 0;
    int unsigned sync_cnt = 0;
    initial begin
        adc_done = 1'b0;
        adc_data = 12'h000;
        sync_in = 1'b0;
    end
    // one shared converter, channels taken one after another
    always @(posedge core_clk) begin
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        if (adc_start_q) begin
            busy_cnt <= CONV_CYC;
        end else if (busy_cnt == 1) begin
            adc_done <= 1'b1;
            adc_data <= chan_level[adc_chan_q];
            busy_cnt <= 0;
        end else if (busy_cnt != 0) begin
            busy_cnt <= busy_cnt - 1;
        end
    end
    // peer pulse train, still while disabled
    always @(posedge core_clk) begin
        sync_cnt <= (sync_cnt + 1 == SYNC_CYC) ? 0 : sync_cnt + 1;
        sync_in <= sync_en && (sync_cnt < 2);
    end
endmodule : mpm_far_model

/* dv/tb_top.sv */
// Purpose: self-checking bench for the phase manager
// Assumes: far model answers conversions and drives the alignment input
// Notes: long waits, the sampling interval is 2000 cycles per stage
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %0t got=%0h exp=%0h", $time, g, e); end end
module tb_top
    import mpm_pkg::*;
;
    logic core_clk = 1'b0;
    logic nrst, align_wr, soft_reset, fault_off_en, light_en, light_coef_en, sync_en;
    logic sync_in, sync_out_q, adc_start_q, adc_done, cfg_invalid_q;
    logic [4:0] stage_assignment_cmd;
    logic [1:0][15:0] rail_period, rail_duty;
    logic [1:0] rail_ramping, fault_clr, shed_num, adc_chan_q, fault_q, shed_q;
    logic [15:0] align_wdata, align_rdata_q;
    logic [3:0] pulse_output_q;
    logic [11:0] adc_data;
    logic [3:0][15:0] current_gain_cal;
    logic [3:0][11:0] current_offset_cal, chan_level;
    logic [1:0][17:0] oc_limit, uc_limit, light_low, light_high, rail_current_q;
    logic [1:0][1:0] bank_q;
    logic [4:0] bad_cfg [4] = '{5'h19, 5'h08, 5'h1a, 5'h05};
    int unsigned checked = 0;
    int unsigned miscompares = 0;
    int cyc = 0;
    int ta, tb, h, i, exp_off;

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    mpm_phase_mgr mpm_phase_mgr_inst (
        .core_clk(core_clk), .nrst(nrst), .stage_assignment_cmd(stage_assignment_cmd),
        .rail_period(rail_period), .rail_duty(rail_duty), .rail_ramping(rail_ramping),
        .align_wr(align_wr), .align_wdata(align_wdata), .align_rdata_q(align_rdata_q),
        .soft_reset(soft_reset), .sync_in(sync_in), .sync_out_q(sync_out_q),
        .pulse_output_q(pulse_output_q), .adc_start_q(adc_start_q), .adc_chan_q(adc_chan_q),
        .adc_done(adc_done), .adc_data(adc_data), .current_gain_cal(current_gain_cal),
        .current_offset_cal(current_offset_cal), .oc_limit(oc_limit), .uc_limit(uc_limit),
        .fault_off_en(fault_off_en), .fault_clr(fault_clr), .fault_q(fault_q),
        .light_en(light_en), .light_coef_en(light_coef_en), .light_low(light_low),
        .light_high(light_high), .shed_num(shed_num), .shed_q(shed_q), .bank_q(bank_q),
        .rail_current_q(rail_current_q), .cfg_invalid_q(cfg_invalid_q)
    );
    mpm_far_model #(.CONV_CYC(5), .SYNC_CYC(80)) mpm_far_model_inst (
        .core_clk(core_clk), .adc_start_q(adc_start_q), .adc_chan_q(adc_chan_q),
        .chan_level(chan_level), .sync_en(sync_en), .adc_done(adc_done),
        .adc_data(adc_data), .sync_in(sync_in)
    );

    task automatic print_verdict;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task automatic wr_route(input logic [15:0] d);
        @(posedge core_clk);
        align_wr <= 1'b1;
        align_wdata <= d;
        @(posedge core_clk);
        align_wr <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        `CHK(align_rdata_q, d)
    endtask : wr_route

    // time of the next rising edge of one output
    task automatic rise(input int b, output int t);
        int n;
        for (n = 0; n < 400 && pulse_output_q[b] !== 1'b0; n++) @(negedge core_clk);
        for (n = 0; n < 400 && pulse_output_q[b] !== 1'b1; n++) @(negedge core_clk);
        t = cyc;
    endtask : rise

    // high cycles of an output (b = 4 alignment output, b = 5 converter start)
    task automatic cnt(input int b, input int len, output int c);
        int k;
        c = 0;
        for (k = 0; k < len; k++) begin
            @(negedge core_clk);
            c += (b == 5) ? int'(adc_start_q === 1'b1) : (b == 4) ? int'(sync_out_q === 1'b1)
                : int'(pulse_output_q[b] === 1'b1);
        end
    endtask : cnt

    initial begin
        #8_000_000;
        miscompares++;
        print_verdict();
    end

    initial begin
        nrst = 1'b0; stage_assignment_cmd = 5'h04; rail_period = {16'd100, 16'd100};
        rail_duty = {16'h4000, 16'h4000}; rail_ramping = 2'h0; align_wr = 1'b0; align_wdata = 16'h0000;
        soft_reset = 1'b0; fault_off_en = 1'b0; fault_clr = 2'h0; light_en = 1'b0; light_coef_en = 1'b0;
        shed_num = 2'h1; sync_en = 1'b0; current_gain_cal = {4{16'h0100}}; current_offset_cal = '0;
        chan_level = '0; oc_limit = {2{18'h3ffff}}; uc_limit = '0; light_low = '0; light_high = {2{18'h3ffff}};
        repeat (5) @(negedge core_clk);
        `CHK(align_rdata_q, ALIGN_ROUTE_RST)
        `CHK(pulse_output_q, 4'h0)
        @(posedge core_clk);
        nrst <= 1'b1;
        // 4:0, quarter duty, four stages spread by a quarter period
        repeat (300) @(negedge core_clk);
        cnt(0, 100, h);
        `CHK(h, (32'h4000 * 100) >> 16)
        rise(0, ta); rise(1, tb);
        `CHK((tb - ta) % 100, 25)
        rise(0, ta); rise(3, tb);
        `CHK((tb - ta) % 100, 75)
        `CHK(cfg_invalid_q, 1'b0)
        for (i = 0; i < 4; i++) begin
            @(posedge core_clk);
            stage_assignment_cmd <= bad_cfg[i];
            repeat (4) @(negedge core_clk);
            `CHK({cfg_invalid_q, pulse_output_q}, 5'h10)
        end
        // 3:1, rail two offset 3/13, 3A moves to rail one
        @(posedge core_clk);
        stage_assignment_cmd <= 5'h0b;
        exp_off = int'((32'd100 * SPREAD_MUL) >> 16);
        repeat (300) @(negedge core_clk);
        rise(0, ta); rise(2, tb);
        `CHK((tb - ta) % 100, exp_off)
        rise(0, ta); rise(3, tb);
        `CHK((tb - ta) % 100, int'((32'd200 * THIRD_MUL) >> 16))
        // 2:2, 3A joins 2A on rail two, half a period apart
        @(posedge core_clk);
        stage_assignment_cmd <= 5'h12;
        repeat (300) @(negedge core_clk);
        rise(2, ta); rise(3, tb);
        `CHK((tb - ta) % 100, 50)
        // following drops the rail spacing until soft reset
        wr_route(16'hff01);
        repeat (300) @(negedge core_clk);
        rise(0, ta); rise(2, tb);
        `CHK((tb - ta) % 100, 0)
        wr_route(16'hff00);
        repeat (300) @(negedge core_clk);
        rise(0, ta); rise(2, tb);
        `CHK((tb - ta) % 100, 0)
        @(posedge core_clk);
        soft_reset <= 1'b1;
        @(posedge core_clk);
        soft_reset <= 1'b0;
        repeat (300) @(negedge core_clk);
        rise(0, ta); rise(2, tb);
        `CHK((tb - ta) % 100, exp_off)
        // faster alignment input locks rail one at 80 cycles
        wr_route(16'h0001);
        @(posedge core_clk);
        sync_en <= 1'b1;
        repeat (300) @(negedge core_clk);
        rise(0, ta); rise(0, tb);
        `CHK(tb - ta, 80)
        cnt(4, 240, h);
        `CHK(h, 3)
        @(posedge core_clk);
        sync_en <= 1'b0;
        for (i = 0; i < 5; i++) begin
            wr_route({i[7:0], 8'h00});
            repeat (50) @(negedge core_clk);
            cnt(4, 300, h);
            `CHK(h, (i < 4) ? 3 : 0)
        end
        // 1:0, offset 200 on a 1000 reading settles near 800
        @(posedge core_clk);
        stage_assignment_cmd <= 5'h01;
        current_offset_cal <= {4{12'd200}};
        oc_limit[0] <= 18'd600;
        chan_level <= {4{12'd1000}};
        repeat (2100) @(negedge core_clk);
        `CHK(fault_q[0], 1'b0)
        `CHK(adc_chan_q, 2'd0)
        cnt(5, 4000, h);
        `CHK(h, 2)
        repeat (10000) @(negedge core_clk);
        `CHK(fault_q, 2'h1)
        `CHK(rail_current_q[0] > 18'd600 && rail_current_q[0] <= 18'd800, 1'b1)
        `CHK(rail_current_q[1], 18'h00000)
        @(posedge core_clk);
        fault_clr <= 2'h1;
        @(posedge core_clk);
        fault_clr <= 2'h0;
        @(negedge core_clk);
        `CHK(fault_q[0], 1'b1)
        // fault response turns the faulted rail's outputs off
        @(posedge core_clk);
        fault_off_en <= 1'b1;
        repeat (2) @(negedge core_clk);
        cnt(0, 100, h);
        `CHK(h, 0)
        // shedding with hysteresis and bank selection
        @(posedge core_clk);
        fault_off_en <= 1'b0;
        light_en <= 1'b1;
        light_coef_en <= 1'b1;
        light_low[0] <= 18'd900;
        repeat (4200) @(negedge core_clk);
        `CHK({shed_q[0], bank_q[0]}, {1'b1, BANK_LIGHT})
        @(posedge core_clk);
        light_low[0] <= 18'd0;
        light_high[0] <= 18'd900;
        repeat (4200) @(negedge core_clk);
        `CHK(shed_q, 2'h1)
        @(posedge core_clk);
        light_high[0] <= 18'd100;
        repeat (4200) @(negedge core_clk);
        `CHK({shed_q[0], bank_q[0]}, {1'b0, BANK_REG})
        @(posedge core_clk);
        rail_ramping <= 2'h3;
        repeat (5) @(negedge core_clk);
        `CHK(bank_q, {BANK_RAMP, BANK_RAMP})
        print_verdict();
    end
endmodule : tb_top
